// [rtl/frgen_pkg.sv]
/*
 * Package for the frame-reference pulse generator: field widths, encodings,
 * reset values, cycle counts and the carrier struct used by the main module.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package frgen_pkg;

    // Field widths.
    localparam int unsigned BURST_W   = 4;
    localparam int unsigned DIVIDE_W  = 11;
    localparam int unsigned HALF_W    = 13;
    localparam int unsigned PRE_W     = 3;
    localparam int unsigned WORD_W    = 6;
    localparam int unsigned CODE_W    = 8;
    localparam int unsigned SUM_W     = 10;
    localparam int unsigned SEL_W     = 2;

    // Encodings of selector and divider fields.
    localparam logic [SEL_W-1:0]  PORT_B_SEL_FRAME_REF = 2'h2;
    localparam logic [PRE_W-1:0]  PREDIV_1             = 3'h1;
    localparam logic [PRE_W-1:0]  PREDIV_2             = 3'h2;
    localparam logic [PRE_W-1:0]  PREDIV_4             = 3'h4;

    // Master divider: half period is base plus twice the code.
    localparam logic [HALF_W-1:0] HALF_BASE            = 13'h0004;

    // Reset values of the configuration fields.
    localparam logic              REPEATER_RESET       = 1'b0;
    localparam logic              BURST_STYLE_RESET    = 1'b0;
    localparam logic [BURST_W-1:0]  BURST_LENGTH_RESET = 4'h4;
    localparam logic [DIVIDE_W-1:0] DIVIDE_RESET       = 11'h000;

    // Phase-shift code construction.
    localparam logic [WORD_W-1:0] WORD_SUM_REQUIRED    = 6'h3F;
    localparam logic [SUM_W-1:0]  CODE_OFFSET          = 10'h01B;
    localparam logic [SUM_W-1:0]  CODE_MAX             = 10'h0F7;
    localparam int unsigned       CODE_STEPS           = 248;
    localparam int unsigned       FINE_STEP_PS         = 9;

    // Clock period of the device clock.
    localparam int unsigned       CLOCK_PERIOD_PS      = 5000;

    // Status carried out of the generator core.
    typedef struct packed {
        logic               active;
        logic               busy;
        logic               pre_invalid;
        logic               code_invalid;
        logic [CODE_W-1:0]  code;
    } frgen_status_s;

endpackage : frgen_pkg

// [rtl/frgen_delay_line.sv]
/*
 * Tapped delay line that sets the port-A to port-B offset in whole steps.
 * Assumes the tap index changes only while the output is not in use.
 */
`timescale 1ns/1ps
`default_nettype none
module frgen_delay_line
    import frgen_pkg::*;
#(
    parameter int unsigned DEPTH = CODE_STEPS
) (
    input  wire logic              CLOCK,
    input  wire logic              RST_N,
    input  wire logic              d,
    input  wire logic [CODE_W-1:0] tap,
    output var  logic              q
);
    logic [DEPTH-1:0] stage;
    logic [DEPTH-1:0] next_stage;
    logic             next_q;

    initial begin
        if (DEPTH < 2 || DEPTH > (1 << CODE_W)) begin
            $error("Delay line depth out of range.");
        end
    end

    // Shift one step per clock and pick the requested tap.
    always_comb begin
        next_stage = {stage[DEPTH-2:0], d};
        next_q     = (int'(tap) < DEPTH) ? stage[tap] : stage[0];
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            stage <= '0;
            q     <= 1'b0;
        end else begin
            stage <= next_stage;
            q     <= next_q;
        end
    end
endmodule // frgen_delay_line
`default_nettype wire

// [rtl/frgen_top.sv]
/*
 * Frame-reference pulse generator driving output port B: pre-divider,
 * request retiming, master pulse engine, repeater path and phase offset.
 * Assumes CLOCK is the divided oscillator clock that also times port A, and
 * that all inputs are synchronous to it except the request and reference pins.
 */
`timescale 1ns/1ps
`default_nettype none
module frgen_top
    import frgen_pkg::*;
(
    input  wire logic                CLOCK,
    input  wire logic                RST_N,
    input  wire logic                SOFT_RESET,
    input  wire logic                POWERDOWN,
    input  wire logic                PHASE_SYNC_MODE,
    input  wire logic                FRAME_REF_ENABLE,
    input  wire logic [SEL_W-1:0]    PORT_B_SOURCE_SELECT,
    input  wire logic [PRE_W-1:0]    INTERP_PREDIVIDE,
    input  wire logic                REPEATER_SELECT,
    input  wire logic                BURST_STYLE_SELECT,
    input  wire logic [BURST_W-1:0]  BURST_LENGTH,
    input  wire logic [DIVIDE_W-1:0] MASTER_OUTPUT_DIVIDE,
    input  wire logic [WORD_W-1:0]   DELAY_WORD_ONE,
    input  wire logic [WORD_W-1:0]   DELAY_WORD_TWO,
    input  wire logic [WORD_W-1:0]   DELAY_WORD_THREE,
    input  wire logic [WORD_W-1:0]   DELAY_WORD_FOUR,
    input  wire logic                REF_OSC,
    input  wire logic                FRAME_REF_REQUEST_PIN,
    output var  logic                OUTPUT_PORT_B,
    output var  logic                FRAME_REF_ACTIVE,
    output var  logic                BURST_BUSY,
    output var  logic                PREDIVIDE_INVALID,
    output var  logic                PHASE_CODE_INVALID,
    output var  logic [CODE_W-1:0]   COMBINED_PHASE_SHIFT_CODE
);
    // Ratio of the pre-divider, zero for an illegal code.
    function automatic logic [PRE_W-1:0] pre_ratio_of(input logic [PRE_W-1:0] c);
        unique case (c)
            PREDIV_1, PREDIV_2, PREDIV_4: pre_ratio_of = c;
            default:                      pre_ratio_of = '0;
        endcase
    endfunction

    // Weighted sum of the delay words before the offset is removed.
    function automatic logic [SUM_W-1:0] word_sum(input logic [WORD_W-1:0] w1,
                                                  input logic [WORD_W-1:0] w2,
                                                  input logic [WORD_W-1:0] w3,
                                                  input logic [WORD_W-1:0] w4);
        word_sum = {2'b00, w1, 2'b00} + {4'h0, w2} + {3'b000, w3, 1'b0}
                 + {4'h0, w4} + {3'b000, w4, 1'b0};
    endfunction

    logic hold;
    logic ref_s1, ref_s2, ref_prev, req_s1, req_s2, req_ref, req_int, req_out, req_prev;
    logic next_ref_prev, next_req_ref, next_req_int, next_req_out, next_req_prev;
    logic [1:0]           pre_cnt, next_pre_cnt;
    logic [PRE_W-1:0]     pre_ratio;
    logic                 interp_tick, ref_tick, req_rise;
    logic [HALF_W-1:0]    half_cnt, next_half_cnt, half_len;
    logic                 pulse_lvl, next_pulse_lvl, busy, next_busy, terminal;
    logic [BURST_W-1:0]   remaining, next_remaining;
    logic                 toggle, next_toggle, active, src, delayed, next_port_b;
    logic [SUM_W-1:0]     wsum;
    logic [WORD_W+1:0]    plain_sum;
    logic                 code_bad;
    frgen_status_s        status, next_status;

    // Soft reset and powerdown both force every register to reset.
    assign hold = !RST_N || SOFT_RESET || POWERDOWN;

    // Two-flop synchronisers; only the second stage is looked at.
    always_ff @(posedge CLOCK) begin
        if (hold) begin
            ref_s1 <= 1'b0;
            ref_s2 <= 1'b0;
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
        end else begin
            ref_s1 <= REF_OSC;
            ref_s2 <= ref_s1;
            req_s1 <= FRAME_REF_REQUEST_PIN;
            req_s2 <= req_s1;
        end
    end

    // Timing strobes: reference edge and interpolator tick from the pre-divider.
    always_comb begin
        pre_ratio    = pre_ratio_of(INTERP_PREDIVIDE);
        ref_tick     = ref_s2 && !ref_prev;
        // An illegal ratio falls back to divide by one so the engine keeps moving.
        interp_tick  = (pre_ratio == '0) || ({1'b0, pre_cnt} >= pre_ratio - 3'h1);
        next_pre_cnt = interp_tick ? 2'h0 : pre_cnt + 2'h1;
        next_ref_prev = ref_s2;
    end

    // Retiming chain: reference stage in master mode only, then interpolator, then output.
    always_comb begin
        next_req_ref  = ref_tick ? req_s2 : req_ref;
        next_req_int  = req_int;
        if (interp_tick) begin
            next_req_int = REPEATER_SELECT ? req_s2 : req_ref;
        end
        next_req_out  = req_int;
        next_req_prev = req_out;
        req_rise      = req_out && !req_prev;
    end

    always_ff @(posedge CLOCK) begin
        if (hold) begin
            ref_prev <= 1'b0;
            pre_cnt  <= 2'h0;
            req_ref  <= 1'b0;
            req_int  <= 1'b0;
            req_out  <= 1'b0;
            req_prev <= 1'b0;
        end else begin
            ref_prev <= next_ref_prev;
            pre_cnt  <= next_pre_cnt;
            req_ref  <= next_req_ref;
            req_int  <= next_req_int;
            req_out  <= next_req_out;
            req_prev <= next_req_prev;
        end
    end

    // Master pulse engine: the level flips every half_len interpolator ticks.
    always_comb begin
        half_len       = {1'b0, MASTER_OUTPUT_DIVIDE, 1'b0} + HALF_BASE;
        terminal       = interp_tick && (half_cnt >= half_len - 13'h0001);
        next_half_cnt  = half_cnt;
        next_pulse_lvl = pulse_lvl;
        next_busy      = busy;
        next_remaining = remaining;
        if (REPEATER_SELECT) begin
            next_half_cnt  = '0;
            next_pulse_lvl = 1'b0;
            next_busy      = 1'b0;
            next_remaining = '0;
        end else if (!BURST_STYLE_SELECT) begin
            next_busy = 1'b0;
            if (!req_out) begin
                next_half_cnt  = '0;
                next_pulse_lvl = 1'b0;
            end else if (terminal) begin
                next_half_cnt  = '0;
                next_pulse_lvl = !pulse_lvl;
            end else if (interp_tick) begin
                next_half_cnt = half_cnt + 13'h0001;
            end
        end else if (!busy) begin
            next_half_cnt  = '0;
            next_pulse_lvl = 1'b0;
            // A zero length is accepted and simply produces no burst.
            if (req_rise && BURST_LENGTH != '0) begin
                next_busy      = 1'b1;
                next_remaining = BURST_LENGTH;
                next_pulse_lvl = 1'b1;
            end
        end else if (terminal) begin
            next_half_cnt = '0;
            if (pulse_lvl) begin
                next_pulse_lvl = 1'b0;
                next_remaining = remaining - 4'h1;
            end else if (remaining == '0) begin
                next_busy = 1'b0;
            end else begin
                next_pulse_lvl = 1'b1;
            end
        end else if (interp_tick) begin
            next_half_cnt = half_cnt + 13'h0001;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (hold) begin
            half_cnt  <= '0;
            pulse_lvl <= 1'b0;
            busy      <= 1'b0;
            remaining <= '0;
        end else begin
            half_cnt  <= next_half_cnt;
            pulse_lvl <= next_pulse_lvl;
            busy      <= next_busy;
            remaining <= next_remaining;
        end
    end

    // Port B mux, phase code and status. Outside frame-reference mode port B
    // carries a plain clock stand-in, toggling every cycle.
    always_comb begin
        // Enable without the matching source select is treated as inactive.
        active      = PHASE_SYNC_MODE && FRAME_REF_ENABLE
                    && (PORT_B_SOURCE_SELECT == PORT_B_SEL_FRAME_REF);
        src         = REPEATER_SELECT ? req_out : pulse_lvl;
        wsum        = word_sum(DELAY_WORD_ONE, DELAY_WORD_TWO,
                               DELAY_WORD_THREE, DELAY_WORD_FOUR);
        plain_sum   = {2'b00, DELAY_WORD_ONE} + {2'b00, DELAY_WORD_TWO}
                    + {2'b00, DELAY_WORD_THREE} + {2'b00, DELAY_WORD_FOUR};
        code_bad    = (wsum < CODE_OFFSET) || (wsum - CODE_OFFSET > CODE_MAX)
                    || (plain_sum != {2'b00, WORD_SUM_REQUIRED});
        next_status.active       = active;
        next_status.busy         = busy;
        next_status.pre_invalid  = (pre_ratio == '0);
        next_status.code_invalid = code_bad;
        next_status.code         = code_bad ? '0 : CODE_W'(wsum - CODE_OFFSET);
        next_toggle = !toggle;
        next_port_b = active ? delayed : toggle;
    end

    always_ff @(posedge CLOCK) begin
        if (hold) begin
            status        <= '0;
            toggle        <= 1'b0;
            OUTPUT_PORT_B <= 1'b0;
        end else begin
            status        <= next_status;
            toggle        <= next_toggle;
            OUTPUT_PORT_B <= next_port_b;
        end
    end

    // Each code step adds one clock of delay; the fine step is not reproduced.
    frgen_delay_line #(.DEPTH(CODE_STEPS)) u_delay (
        .CLOCK (CLOCK),
        .RST_N (!hold),
        .d     (src),
        .tap   (status.code),
        .q     (delayed)
    );

    assign FRAME_REF_ACTIVE          = status.active;
    assign BURST_BUSY                = status.busy;
    assign PREDIVIDE_INVALID         = status.pre_invalid;
    assign PHASE_CODE_INVALID        = status.code_invalid;
    assign COMBINED_PHASE_SHIFT_CODE = status.code;

    // Checks on the generator's own behaviour.
    a_predivide_four: assert property (@(posedge CLOCK) disable iff (hold)
        (pre_ratio == 3'h4)[*4] ##0 interp_tick |->
        !$past(interp_tick, 1) && !$past(interp_tick, 2) && !$past(interp_tick, 3))
        else $error("Divide-by-four pre-divider ticked early.");
    a_repeater_follow: assert property (@(posedge CLOCK) disable iff (hold)
        REPEATER_SELECT && interp_tick |=> req_int == $past(req_s2))
        else $error("Repeater path did not take the request level.");
    a_burst_load: assert property (@(posedge CLOCK) disable iff (hold)
        !REPEATER_SELECT && BURST_STYLE_SELECT && !busy && req_rise && BURST_LENGTH != '0
        |=> busy && pulse_lvl && remaining == $past(BURST_LENGTH))
        else $error("Burst did not start with the programmed length.");
    a_zero_burst: assert property (@(posedge CLOCK) disable iff (hold)
        !REPEATER_SELECT && BURST_STYLE_SELECT && !busy && BURST_LENGTH == '0 |=> !busy)
        else $error("Zero burst length started a burst.");
    a_half_period: assert property (@(posedge CLOCK) disable iff (hold)
        !REPEATER_SELECT && !BURST_STYLE_SELECT && req_out && terminal
        |=> pulse_lvl != $past(pulse_lvl))
        else $error("Continuous stream missed a half-period flip.");
    a_cont_stop: assert property (@(posedge CLOCK) disable iff (hold)
        !REPEATER_SELECT && !BURST_STYLE_SELECT && !req_out |=> !pulse_lvl)
        else $error("Continuous stream ran with request low.");
    a_ref_retime: assert property (@(posedge CLOCK) disable iff (hold)
        req_ref != $past(req_ref) |-> $past(ref_tick))
        else $error("Reference stage changed without a reference edge.");
    a_port_b_clock: assert property (@(posedge CLOCK) disable iff (hold)
        !active ##1 !active |=> OUTPUT_PORT_B != $past(OUTPUT_PORT_B))
        else $error("Port B did not carry a clock outside frame-reference mode.");
    a_code_range: assert property (@(posedge CLOCK) disable iff (hold)
        wsum > CODE_MAX + CODE_OFFSET |=> PHASE_CODE_INVALID && COMBINED_PHASE_SHIFT_CODE == '0)
        else $error("Phase code above range was not flagged.");
    a_soft_reset: assert property (@(posedge CLOCK) disable iff (!RST_N)
        SOFT_RESET && !POWERDOWN |=> !BURST_BUSY && !OUTPUT_PORT_B && !FRAME_REF_ACTIVE)
        else $error("Soft reset did not clear the generator.");
    c_burst_done: cover property (@(posedge CLOCK) disable iff (hold) busy ##1 !busy);
    c_cont_flip: cover property (@(posedge CLOCK) disable iff (hold)
        !BURST_STYLE_SELECT && $rose(pulse_lvl));
    c_repeater_out: cover property (@(posedge CLOCK) disable iff (hold)
        REPEATER_SELECT && active && $rose(req_out));
endmodule // frgen_top
`default_nettype wire

// [bench/frgen_converter_model.sv]
/*
 * Behavioural model of the data converter that receives the frame
 * reference from output port B: counts pulses and measures their width.
 * Assumes port B is a registered output of the same device clock.
 */
`timescale 1ns/1ps
`default_nettype none
module frgen_converter_model (
    input  wire logic        CLOCK,
    input  wire logic        clear,
    input  wire logic        frame_ref_in,
    output var  logic [15:0] pulse_count,
    output var  logic [15:0] high_width
);
    logic        prev = 1'b0;
    logic [15:0] run  = 16'h0000;

    // A real receiver only sees edges, so width is taken at each falling edge.
    always_ff @(posedge CLOCK) begin
        prev <= frame_ref_in;
        if (clear) begin
            pulse_count <= 16'h0000;
            high_width  <= 16'h0000;
            run         <= 16'h0000;
        end else begin
            if (frame_ref_in && !prev) pulse_count <= pulse_count + 16'h0001;
            run <= frame_ref_in ? run + 16'h0001 : 16'h0000;
            if (!frame_ref_in && prev) high_width <= run;
        end
    end
endmodule // frgen_converter_model
`default_nettype wire

// [bench/test_frame_ref_pulse_generator.sv]
/*
 * Self-checking bench for the frame-reference generator top module.
 * Assumes the converter model on port B and a reference at a quarter rate.
 */
`timescale 1ns/1ps
`default_nettype none
module test_frame_ref_pulse_generator
    import frgen_pkg::*;
;
    logic clock = 1'b0, rst_n = 1'b0, soft_reset = 1'b0, powerdown = 1'b0;
    // The request is driven as a plain single-ended level in every mode.
    logic sync = 1'b1, enable = 1'b0, rep = 1'b0, style = 1'b0, req = 1'b0;
    logic ref_osc = 1'b0, clr = 1'b0;
    logic [1:0]  ref_div = 2'h0;
    logic [SEL_W-1:0]    sel = 2'h2;
    logic [PRE_W-1:0]    pre = 3'h1;
    logic [BURST_W-1:0]  len = 4'h4;
    logic [DIVIDE_W-1:0] div = 11'h000;
    logic [WORD_W-1:0]   w1 = 6'h00, w2 = 6'h3F, w3 = 6'h00, w4 = 6'h00;
    logic port_b, active, busy, pre_inv, code_inv;
    logic [CODE_W-1:0] code;
    logic [15:0] cnt, hw;
    int bad_count = 0, total_checks = 0;

    always #2.5 clock = ~clock;

    // Reference runs at a quarter of the device clock, as the interpolator
    // rate must be a multiple of it.
    always @(negedge clock) begin
        ref_div <= ref_div + 2'h1;
        ref_osc <= ref_div[1];
    end

    frgen_top dut_u (
        .CLOCK(clock), .RST_N(rst_n), .SOFT_RESET(soft_reset), .POWERDOWN(powerdown),
        .PHASE_SYNC_MODE(sync), .FRAME_REF_ENABLE(enable), .PORT_B_SOURCE_SELECT(sel),
        .INTERP_PREDIVIDE(pre), .REPEATER_SELECT(rep), .BURST_STYLE_SELECT(style),
        .BURST_LENGTH(len), .MASTER_OUTPUT_DIVIDE(div),
        .DELAY_WORD_ONE(w1), .DELAY_WORD_TWO(w2), .DELAY_WORD_THREE(w3),
        .DELAY_WORD_FOUR(w4), .REF_OSC(ref_osc), .FRAME_REF_REQUEST_PIN(req),
        .OUTPUT_PORT_B(port_b), .FRAME_REF_ACTIVE(active), .BURST_BUSY(busy),
        .PREDIVIDE_INVALID(pre_inv), .PHASE_CODE_INVALID(code_inv),
        .COMBINED_PHASE_SHIFT_CODE(code)
    );

    frgen_converter_model conv_u (
        .CLOCK(clock), .clear(clr), .frame_ref_in(port_b),
        .pulse_count(cnt), .high_width(hw)
    );

    // Compare one value and count it.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic clear_model();
        clr = 1'b1;
        @(negedge clock);
        clr = 1'b0;
    endtask

    // Delay words may only move while the output is inactive.
    task automatic set_words(input logic [5:0] a, b, c, d);
        enable = 1'b0;
        {w1, w2, w3, w4} = {a, b, c, d};
        @(negedge clock);
    endtask

    // Activate and let the delay line flush before any request.
    task automatic go();
        enable = 1'b1;
        repeat (300) @(negedge clock);
    endtask

    task automatic setup(input logic r, s, input logic [3:0] l,
                         input logic [10:0] n, input logic [2:0] p);
        req = 1'b0;
        set_words(6'h00, 6'h3F, 6'h00, 6'h00);
        {rep, style, len, div, pre} = {r, s, l, n, p};
        go();
    endtask

    task automatic t_reset();
        setup(1'b0, 1'b0, 4'h4, 11'h000, 3'h3);
        for (int i = 0; i < 2; i++) begin
            soft_reset = (i == 0);
            powerdown  = (i == 1);
            repeat (3) @(negedge clock);
            check({port_b, active, busy, pre_inv, code_inv, code}, 32'h0000_0000);
            soft_reset = 1'b0;
            powerdown  = 1'b0;
            repeat (3) @(negedge clock);
            check(pre_inv, 32'h0000_0001);
        end
        $display("done: reset");
    endtask

    task automatic t_modes();
        for (int i = 0; i < 16; i++) begin
            {sync, enable, sel} = i[3:0];
            repeat (2) @(negedge clock);
            check(active, sync & enable & (sel == 2'h2));
        end
        for (int i = 0; i < 8; i++) begin
            pre = i[2:0];
            repeat (2) @(negedge clock);
            check(pre_inv, !(i == 1 || i == 2 || i == 4));
        end
        {sync, sel} = 3'h6;
        $display("done: modes");
    endtask

    task automatic row(input logic [5:0] a, b, c, d, input logic [7:0] k, input logic v);
        set_words(a, b, c, d);
        repeat (3) @(negedge clock);
        check({code_inv, code}, {v, k});
    endtask

    task automatic t_phase();
        row(6'h24, 6'h1B, 6'h00, 6'h00, 8'h90, 1'b0);
        row(6'h00, 6'h3F, 6'h00, 6'h00, 8'h24, 1'b0);
        row(6'h00, 6'h00, 6'h3F, 6'h00, 8'h63, 1'b0);
        row(6'h00, 6'h00, 6'h3E, 6'h01, 8'h64, 1'b0);
        row(6'h00, 6'h00, 6'h01, 6'h3E, 8'hA1, 1'b0);
        row(6'h00, 6'h00, 6'h00, 6'h3F, 8'hA2, 1'b0);
        row(6'h01, 6'h00, 6'h00, 6'h3E, 8'hA3, 1'b0);
        row(6'h3F, 6'h00, 6'h00, 6'h00, 8'hE1, 1'b0);
        row(6'h3E, 6'h01, 6'h00, 6'h00, 8'hDE, 1'b0);
        row(6'h29, 6'h16, 6'h00, 6'h00, 8'h9F, 1'b0);
        row(6'h3F, 6'h3F, 6'h00, 6'h00, 8'h00, 1'b1);
        row(6'h00, 6'h00, 6'h00, 6'h00, 8'h00, 1'b1);
        $display("done: phase");
    endtask

    // One burst request plus, for lengths above 2, a second edge that lands inside the burst.
    task automatic burst(input logic [3:0] l, input logic [10:0] n, input logic [2:0] p);
        setup(1'b0, 1'b1, l, n, p);
        clear_model();
        req = 1'b1;
        repeat (10) @(negedge clock);
        req = 1'b0;
        repeat (5) @(negedge clock);
        check(busy, l != 4'h0);
        req = (l > 4'h2);
        repeat (10) @(negedge clock);
        req = 1'b0;
        repeat (900) @(negedge clock);
        check({16'h0000, cnt}, {28'h000_0000, l});
        check(busy, 32'h0000_0000);
        if (l != 4'h0) check({16'h0000, hw}, (4 + 2 * n) * p);
    endtask

    task automatic t_continuous();
        setup(1'b0, 1'b0, 4'h4, 11'h000, 3'h1);
        req = 1'b1;
        repeat (300) @(negedge clock);
        clear_model();
        repeat (160) @(negedge clock);
        check({16'h0000, cnt}, 32'h0000_0014);
        check({16'h0000, hw}, 32'h0000_0004);
        req = 1'b0;
        repeat (400) @(negedge clock);
        clear_model();
        repeat (100) @(negedge clock);
        check({16'h0000, cnt}, 32'h0000_0000);
        $display("done: continuous");
    endtask

    // Hold the request 40 cycles and time the echo on port B.
    task automatic echo(output int lat);
        clear_model();
        lat = 0;
        fork
            begin
                req = 1'b1;
                repeat (40) @(negedge clock);
                req = 1'b0;
            end
            while (port_b !== 1'b1 && lat < 600) begin
                @(negedge clock);
                lat++;
            end
        join
        repeat (400) @(negedge clock);
        check({16'h0000, hw}, 32'h0000_0028);
    endtask

    task automatic t_repeater();
        int a;
        int b;
        setup(1'b1, 1'b0, 4'h4, 11'h000, 3'h1);
        echo(a);
        set_words(6'h00, 6'h00, 6'h3F, 6'h00);
        go();
        echo(b);
        check(32'(b - a), 32'h0000_003F);
        $display("done: repeater");
    endtask

    // Watchdog sized well above the roughly 9400 cycles the tests need.
    initial begin
        repeat (30000) @(posedge clock);
        bad_count++;
        results();
    end

    initial begin
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        t_reset();
        t_modes();
        t_phase();
        burst(4'h4, 11'h000, 3'h1);
        burst(4'h1, 11'h001, 3'h2);
        burst(4'hF, 11'h000, 3'h1);
        burst(4'h0, 11'h000, 3'h1);
        burst(4'h3, 11'h003, 3'h4);
        $display("done: bursts");
        t_continuous();
        t_repeater();
        results();
    end
endmodule // test_frame_ref_pulse_generator
`default_nettype wire
